// *** lat_pkg.sv ***
// shared constants for the light converter timing block and its host end
// assumes a single 250 MHz clock shared by both ends
package lat_pkg;
    // clock and documented times
    localparam int unsigned CLK_MHZ       = 250;
    localparam int unsigned INTERVAL_US   = 2700;
    localparam int unsigned PWR_WAIT_MS   = 2;
    localparam int unsigned INTERVAL_CYC  = INTERVAL_US * CLK_MHZ;
    localparam int unsigned PWR_WAIT_CYC  = PWR_WAIT_MS * 1000 * CLK_MHZ;
    localparam int unsigned CNT_W         = 20;

    // command byte layout
    localparam int unsigned CMD_TRANS_LSB = 5;
    localparam logic [1:0]  TRANS_SPECIAL = 2'h3;
    localparam logic [4:0]  FN_INT_CLEAR  = 5'h01;
    localparam logic [4:0]  FN_STOP_MAN   = 5'h02;
    localparam logic [4:0]  FN_START_MAN  = 5'h03;

    // device register offsets
    localparam logic [4:0]  ADR_CTRL      = 5'h00;
    localparam logic [4:0]  ADR_PERIOD    = 5'h01;
    localparam logic [4:0]  ADR_MTIM_LO   = 5'h08;
    localparam logic [4:0]  ADR_MTIM_HI   = 5'h09;

    // control register fields, reset values and period code limits
    localparam int unsigned CTRL_POWER    = 0;
    localparam int unsigned CTRL_ADC_EN   = 1;
    localparam int unsigned CTRL_DONE     = 4;
    localparam int unsigned CTRL_IRQ      = 5;
    localparam logic [7:0]  CTRL_WR_MASK  = 8'h03;
    localparam logic [7:0]  CTRL_RESET    = 8'h00;
    localparam logic [7:0]  PERIOD_RESET  = 8'h00;
    localparam logic [7:0]  PERIOD_LAST   = 8'hFF;
    localparam logic [7:0]  SEND_BYTE_MAX = 8'h7F;

    // host wishbone register byte offsets
    localparam logic [7:0]  WB_CMD        = 8'h00;
    localparam logic [7:0]  WB_STATUS     = 8'h04;
    localparam logic [7:0]  WB_IRQ_STAT   = 8'h08;
    localparam logic [7:0]  WB_IRQ_MASK   = 8'h0C;
    // host command word fields
    localparam int unsigned HC_DATA_LSB   = 0;
    localparam int unsigned HC_ADR_LSB    = 8;
    localparam int unsigned HC_TRANS_LSB  = 13;
    localparam int unsigned HC_READ       = 16;
    localparam int unsigned HC_SENDB      = 17;
    // host interrupt bits
    localparam int unsigned IRQ_DONE      = 0;
    localparam int unsigned IRQ_REFUSED   = 1;
    localparam int unsigned IRQ_DEV       = 2;
endpackage

// *** lat_if.sv ***
// link between the light converter device and its host controller
// assumes both ends run on the same clock; the interrupt wire is pulled up
interface lat_if;
    logic       req;       // host holds a command until ack
    logic [7:0] cmd;       // command byte
    logic [7:0] wdata;     // write data byte
    logic       rd;        // read byte form
    logic       sendb;     // send byte form, no data phase
    logic       ack;       // one cycle answer from device
    logic [7:0] rdata;     // read data, valid with ack
    logic       irq_dout;  // open drain output value
    logic       irq_oe_n;  // low while the device pulls the line
    logic       irq_line;  // resolved wire level

    assign irq_line = irq_oe_n ? 1'b1 : irq_dout;

    modport dev  (input req, cmd, wdata, rd, sendb,
                  output ack, rdata, irq_dout, irq_oe_n);
    modport host (output req, cmd, wdata, rd, sendb,
                  input ack, rdata, irq_line);
endinterface

// *** lat_dev.sv ***
// device end: control, integration timing and manual integration logic
// assumes the host keeps req high until it sees ack, then drops it
// Behaviour
// (RQ1) bit 5 reads pending interrupt, not writable
// (RQ2) bit 4 set when integration cycle completes
// (RQ3) bit 1 enables or disables both converters
// (RQ4) bit 0 powers device on or off
// (RQ5) host writes zeros to reserved control bits
// (RQ6) host sets power and enable before conversions
// (RQ7) host waits 2 ms between power and enable
// (RQ8) host configures registers before enabling converters; lat_host passes period writes on to the device at any time, enabled or not
// (RQ9) period register resets to zero, manual mode
// (RQ10) nonzero code counts 256 minus code intervals
// (RQ11) code zero selects manual timing mode
// (RQ12) code one gives longest, 255 intervals
// (RQ13) no send byte for codes above 127
// (RQ14) transaction field 11 selects special function
// (RQ15) function 00011 starts manual integration
// (RQ16) function 00010 stops it, length readable
// (RQ17) fixed mode restarts after each done cycle
//
// The Wishbone interface to the registers was chosen for this implementation.
module lat_dev #(
    parameter int unsigned INTERVAL_CYC = lat_pkg::INTERVAL_CYC
) (
    input  wire logic clk_i,         // 250 MHz clock
    input  wire logic rst_i,         // synchronous reset, active high
    lat_if.dev        link,          // link to the host
    input  wire logic intr_set_i,    // pulse from threshold logic
    output logic      powered_o,     // power bit
    output logic      adc_en_o,      // converter enable bit
    output logic      integrating_o, // an integration is running
    output logic      cycle_done_o   // one cycle pulse per finished cycle
);
    logic [lat_pkg::CNT_W-1:0] div;
    logic [lat_pkg::CNT_W-1:0] next_div;
    logic                      power;
    logic                      next_power;
    logic                      adc_en;
    logic                      next_adc_en;
    logic                      done_flag;
    logic                      next_done_flag;
    logic                      pending;
    logic                      next_pending;
    logic [7:0]                period;
    logic [7:0]                next_period;
    logic [7:0]                icnt;
    logic [7:0]                next_icnt;
    logic                      man_run;
    logic                      next_man_run;
    logic [15:0]               mcount;
    logic [15:0]               next_mcount;
    logic [15:0]               mtimer;
    logic [15:0]               next_mtimer;
    logic                      ack;
    logic                      next_ack;
    logic [7:0]                rdata;
    logic [7:0]                next_rdata;
    logic                      integ;
    logic                      next_integ;
    logic                      done_p;
    logic                      next_done_p;
    logic                      tick;
    logic                      take;
    logic                      special;
    logic [4:0]                fn;
    logic                      done_set;

    function automatic logic [7:0] read_reg(
        input logic [4:0]  adr,
        input logic [7:0]  ctrl_v,
        input logic [7:0]  per_v,
        input logic [15:0] mt_v
    );
        logic [7:0] v;
        v = 8'h00;
        if (adr == lat_pkg::ADR_CTRL) begin
            v = ctrl_v;
        end else if (adr == lat_pkg::ADR_PERIOD) begin
            v = per_v;
        end else if (adr == lat_pkg::ADR_MTIM_LO) begin
            v = mt_v[7:0];
        end else if (adr == lat_pkg::ADR_MTIM_HI) begin
            v = mt_v[15:8];
        end
        return v;
    endfunction

    always_comb begin
        next_div       = div;
        next_power     = power;
        next_adc_en    = adc_en;
        next_done_flag = done_flag;
        next_pending   = pending;
        next_period    = period;
        next_icnt      = icnt;
        next_man_run   = man_run;
        next_mcount    = mcount;
        next_mtimer    = mtimer;
        next_rdata     = rdata;
        done_set       = 1'b0;
        tick           = 1'b0;

        // interval divider only runs while converting is allowed
        if (power && adc_en) begin
            if (div == lat_pkg::CNT_W'(INTERVAL_CYC - 1)) begin
                next_div = '0;
                tick     = 1'b1;
            end else begin
                next_div = div + lat_pkg::CNT_W'(1);
            end
        end else begin
            next_div = '0;
        end

        take     = link.req && !ack;
        next_ack = take;
        fn       = link.cmd[4:0];
        special  = link.cmd[lat_pkg::CMD_TRANS_LSB +: 2]
                   == lat_pkg::TRANS_SPECIAL;                       // [RQ14]

        // fixed period: count up from the code to the last code
        if (period != 8'h00 && power && adc_en) begin              // [RQ17]
            if (tick) begin
                if (icnt == lat_pkg::PERIOD_LAST) begin            // [RQ10]
                    next_icnt = period;                            // [RQ12]
                    done_set  = 1'b1;
                end else begin
                    next_icnt = icnt + 8'h01;
                end
            end
        end else begin
            next_icnt = period;
        end

        if (man_run && tick && mcount != 16'hFFFF) begin
            next_mcount = mcount + 16'h0001;
        end

        if (take) begin
            if (link.sendb && special) begin
                if (fn == lat_pkg::FN_INT_CLEAR) begin
                    next_pending = 1'b0;
                end else if (fn == lat_pkg::FN_START_MAN
                             && period == 8'h00) begin             // [RQ15]
                    next_man_run = 1'b1;
                    next_mcount  = 16'h0000;
                end else if (fn == lat_pkg::FN_STOP_MAN
                             && period == 8'h00 && man_run) begin  // [RQ16]
                    next_man_run = 1'b0;
                    next_mtimer  = mcount;
                    done_set     = 1'b1;
                end
            end else if (link.rd) begin
                next_rdata = read_reg(link.cmd[4:0],
                    {2'b00, pending, done_flag, 2'b00, adc_en, power},
                    period, mtimer);                                // [RQ1]
            end else if (!link.sendb && !special) begin
                if (link.cmd[4:0] == lat_pkg::ADR_CTRL) begin
                    // status bits and reserved bits ignore writes
                    next_power  = link.wdata[lat_pkg::CTRL_POWER];  // [RQ4]
                    next_adc_en = link.wdata[lat_pkg::CTRL_ADC_EN]; // [RQ3]
                end else if (link.cmd[4:0] == lat_pkg::ADR_PERIOD) begin
                    next_period  = link.wdata;                      // [RQ11]
                    next_icnt    = link.wdata;
                    next_man_run = 1'b0;
                end
            end
        end

        // turning converters off abandons any running cycle
        if (!next_power || !next_adc_en) begin
            next_man_run   = 1'b0;
            next_done_flag = 1'b0;
        end
        // a finishing cycle wins over a clear in the same cycle
        if (done_set) begin
            next_done_flag = 1'b1;                                 // [RQ2]
        end
        if (intr_set_i) begin
            next_pending = 1'b1;
        end

        next_integ  = next_power && next_adc_en
                      && (next_period != 8'h00 || next_man_run);
        next_done_p = done_set;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            div       <= '0;
            power     <= lat_pkg::CTRL_RESET[lat_pkg::CTRL_POWER];
            adc_en    <= lat_pkg::CTRL_RESET[lat_pkg::CTRL_ADC_EN];
            done_flag <= 1'b0;
            pending   <= 1'b0;
            period    <= lat_pkg::PERIOD_RESET;                     // [RQ9]
            icnt      <= lat_pkg::PERIOD_RESET;
            man_run   <= 1'b0;
            mcount    <= 16'h0000;
            mtimer    <= 16'h0000;
            ack       <= 1'b0;
            rdata     <= 8'h00;
            integ     <= 1'b0;
            done_p    <= 1'b0;
        end else begin
            div       <= next_div;
            power     <= next_power;
            adc_en    <= next_adc_en;
            done_flag <= next_done_flag;
            pending   <= next_pending;
            period    <= next_period;
            icnt      <= next_icnt;
            man_run   <= next_man_run;
            mcount    <= next_mcount;
            mtimer    <= next_mtimer;
            ack       <= next_ack;
            rdata     <= next_rdata;
            integ     <= next_integ;
            done_p    <= next_done_p;
        end
    end

    assign link.ack      = ack;
    assign link.rdata    = rdata;
    assign link.irq_dout = 1'b0;
    assign link.irq_oe_n = !pending;                               // [RQ1]
    assign powered_o     = power;
    assign adc_en_o      = adc_en;
    assign integrating_o = integ;
    assign cycle_done_o  = done_p;
endmodule

// *** lat_host.sv ***
// host end: wishbone slave that turns register writes into link commands
// assumes software polls busy or waits for the done interrupt between commands
module lat_host #(
    parameter int unsigned PWR_WAIT_CYC = lat_pkg::PWR_WAIT_CYC
) (
    input  wire logic        clk_i,    // 250 MHz clock
    input  wire logic        rst_i,    // synchronous reset, active high
    input  wire logic        wb_cyc_i, // wishbone cycle
    input  wire logic        wb_stb_i, // wishbone strobe
    input  wire logic        wb_we_i,  // wishbone write
    input  wire logic [7:0]  wb_adr_i, // byte address
    input  wire logic [3:0]  wb_sel_i, // byte enables
    input  wire logic [31:0] wb_dat_i, // write data
    output logic      [31:0] wb_dat_o, // read data
    output logic             wb_ack_o, // one cycle acknowledge
    output logic             irq_o,    // level interrupt
    lat_if.host              link      // link to the device
);
    typedef enum logic [2:0] {
        LH_IDLE = 3'b001,
        LH_SEND = 3'b010,
        LH_WAIT = 3'b100
    } lat_hstate_t;

    lat_hstate_t               st;
    lat_hstate_t               next_st;
    logic [lat_pkg::CNT_W-1:0] pcnt;
    logic [lat_pkg::CNT_W-1:0] next_pcnt;
    logic pwr_sh, next_pwr_sh, pwr_ok, next_pwr_ok, pend_en, next_pend_en;
    logic req, next_req, rd, next_rd, sendb, next_sendb, refused;
    logic next_refused, ack, next_ack, irq, next_irq, line_s1, line_s2;
    logic [7:0]  cmd, next_cmd, wdata, next_wdata, rbyte, next_rbyte;
    logic [2:0]  istat, next_istat, imask, next_imask, ev;
    logic [31:0] dat, next_dat;
    logic        wr, acc;
    logic [7:0]  d;

    always_comb begin
        next_st = st;  next_pcnt = pcnt;  next_pwr_sh = pwr_sh;
        next_pwr_ok = pwr_ok;  next_pend_en = pend_en;  next_req = req;
        next_rd = rd;  next_sendb = sendb;  next_cmd = cmd;
        next_wdata = wdata;  next_rbyte = rbyte;  next_refused = refused;
        next_imask = imask;  next_dat = dat;  ev = 3'b000;
        acc  = wb_cyc_i && wb_stb_i && !ack;
        wr   = acc && wb_we_i;
        next_ack = acc;
        d = wb_dat_i[lat_pkg::HC_DATA_LSB +: 8];

        if (pwr_sh && !pwr_ok) begin                               // [RQ7]
            if (pcnt == lat_pkg::CNT_W'(PWR_WAIT_CYC - 1)) begin
                next_pwr_ok = 1'b1;
            end else begin
                next_pcnt = pcnt + lat_pkg::CNT_W'(1);
            end
        end

        case (st)
            LH_IDLE: begin
                if (wr && wb_adr_i == lat_pkg::WB_CMD) begin
                    next_cmd = {1'b1,
                        wb_dat_i[lat_pkg::HC_TRANS_LSB +: 2],
                        wb_dat_i[lat_pkg::HC_ADR_LSB +: 5]};
                    next_rd    = wb_dat_i[lat_pkg::HC_READ];
                    next_sendb = wb_dat_i[lat_pkg::HC_SENDB];
                    next_wdata = d;
                    next_refused = 1'b0;
                    if (wb_dat_i[lat_pkg::HC_ADR_LSB +: 5]
                        == lat_pkg::ADR_CTRL) begin
                        next_wdata = d & lat_pkg::CTRL_WR_MASK;    // [RQ5]
                    end
                    if (wb_dat_i[lat_pkg::HC_SENDB]
                        && wb_dat_i[lat_pkg::HC_ADR_LSB +: 5]
                           == lat_pkg::ADR_PERIOD
                        && d > lat_pkg::SEND_BYTE_MAX) begin       // [RQ13]
                        next_refused = 1'b1;
                        ev[lat_pkg::IRQ_REFUSED] = 1'b1;
                    end else if (!wb_dat_i[lat_pkg::HC_READ]
                        && !wb_dat_i[lat_pkg::HC_SENDB]
                        && wb_dat_i[lat_pkg::HC_ADR_LSB +: 5]
                           == lat_pkg::ADR_CTRL
                        && d[lat_pkg::CTRL_ADC_EN]) begin
                        if (!d[lat_pkg::CTRL_POWER]) begin         // [RQ6]
                            next_refused = 1'b1;
                            ev[lat_pkg::IRQ_REFUSED] = 1'b1;
                        end else begin
                            // while power has not settled, power goes out first and enable after the wait; once settled both go in one write
                            next_pend_en = !pwr_ok;                // [RQ7]
                            if (!pwr_ok) begin
                                next_wdata = d & 8'h01;
                            end
                            next_req = 1'b1;
                            next_st  = LH_SEND;
                        end
                    end else begin
                        next_req = 1'b1;
                        next_st  = LH_SEND;
                    end
                end
            end
            LH_SEND: begin
                if (link.ack) begin
                    next_req   = 1'b0;
                    next_rbyte = link.rdata;
                    if (!rd && !sendb && cmd[4:0] == lat_pkg::ADR_CTRL) begin
                        next_pwr_sh = wdata[lat_pkg::CTRL_POWER];
                        if (!wdata[lat_pkg::CTRL_POWER] || !pwr_sh) begin
                            next_pwr_ok = 1'b0;
                            next_pcnt   = '0;
                        end
                    end
                    if (pend_en) begin
                        next_st = LH_WAIT;
                    end else begin
                        next_st = LH_IDLE;
                        ev[lat_pkg::IRQ_DONE] = 1'b1;
                    end
                end
            end
            LH_WAIT: begin
                if (pwr_ok) begin                                  // [RQ7]
                    next_wdata   = wdata | 8'h02;
                    next_pend_en = 1'b0;
                    next_req     = 1'b1;
                    next_st      = LH_SEND;
                end
            end
            default: next_st = LH_IDLE;
        endcase

        ev[lat_pkg::IRQ_DEV] = !line_s2;
        next_istat = istat;
        if (wr && wb_adr_i == lat_pkg::WB_IRQ_STAT && wb_sel_i[0]) begin
            next_istat = istat & ~wb_dat_i[2:0];
        end
        if (wr && wb_adr_i == lat_pkg::WB_IRQ_MASK && wb_sel_i[0]) begin
            next_imask = wb_dat_i[2:0];
        end
        next_istat = next_istat | ev;
        next_irq   = |(next_istat & next_imask);

        if (acc && !wb_we_i) begin
            if (wb_adr_i == lat_pkg::WB_STATUS) begin
                next_dat = {15'h0000, line_s2, rbyte, 5'h00, pwr_ok,
                            refused, st != LH_IDLE};
            end else if (wb_adr_i == lat_pkg::WB_IRQ_STAT) begin
                next_dat = {29'h0000_0000, istat};
            end else if (wb_adr_i == lat_pkg::WB_IRQ_MASK) begin
                next_dat = {29'h0000_0000, imask};
            end else begin
                next_dat = 32'h0000_0000;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st <= LH_IDLE;  pcnt <= '0;  pwr_sh <= 1'b0;  pwr_ok <= 1'b0;
            pend_en <= 1'b0;  req <= 1'b0;  rd <= 1'b0;  sendb <= 1'b0;
            cmd <= 8'h00;  wdata <= 8'h00;  rbyte <= 8'h00;
            refused <= 1'b0;  ack <= 1'b0;  irq <= 1'b0;
            istat <= 3'b000;  imask <= 3'b000;  dat <= 32'h0000_0000;
            line_s1 <= 1'b1;  line_s2 <= 1'b1;
        end else begin
            st <= next_st;  pcnt <= next_pcnt;  pwr_sh <= next_pwr_sh;
            pwr_ok <= next_pwr_ok;  pend_en <= next_pend_en;
            req <= next_req;  rd <= next_rd;  sendb <= next_sendb;
            cmd <= next_cmd;  wdata <= next_wdata;  rbyte <= next_rbyte;
            refused <= next_refused;  ack <= next_ack;  irq <= next_irq;
            istat <= next_istat;  imask <= next_imask;  dat <= next_dat;
            // the line is a wire from outside, so it is resynchronised
            line_s1 <= link.irq_line;
            line_s2 <= line_s1;
        end
    end

    assign link.req   = req;
    assign link.cmd   = cmd;
    assign link.wdata = wdata;
    assign link.rd    = rd;
    assign link.sendb = sendb;
    assign wb_dat_o   = dat;
    assign wb_ack_o   = ack;
    assign irq_o      = irq;
endmodule

// *** lat_sva.sv ***
// link checker for the host and device ends of the light converter block
// assumes it sits beside the one lat_if that joins the two ends
module lat_sva #(
    parameter int unsigned PWR_WAIT_CYC = lat_pkg::PWR_WAIT_CYC
) (
    input wire logic       clk_i,    // clock
    input wire logic       rst_i,    // sync reset, active high
    input wire logic       req,      // host request
    input wire logic [7:0] cmd,      // command byte
    input wire logic [7:0] wdata,    // write byte
    input wire logic       rd,       // read form
    input wire logic       sendb,    // send byte form
    input wire logic       ack,      // device answer
    input wire logic [7:0] rdata,    // read byte
    input wire logic       irq_line  // resolved interrupt wire
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    logic        last_pw;
    logic        next_last_pw;
    logic [31:0] gap;
    logic [31:0] next_gap;
    wire         ctrl_wr = req && !rd && !sendb && cmd[6:0] == 7'h00;
    // gap counts cycles since power went from off to on; saturates
    always_comb begin
        next_last_pw = (ack && ctrl_wr) ? wdata[0] : last_pw;
        next_gap = gap + {31'h0, !gap[31]};
        if (ack && ctrl_wr && wdata[0] && !last_pw) begin
            next_gap = 32'h0;
        end
    end
    always_ff @(posedge clk_i) begin
        last_pw <= rst_i ? 1'b0 : next_last_pw;
        gap     <= rst_i ? 32'h0 : next_gap;
    end
    AST_ACK_AFTER_REQ: assert property ($rose(req) |=> ack)
        else $error("no ack one cycle after request");
    AST_ACK_PULSE: assert property (ack |=> !ack)
        else $error("ack longer than one cycle");
    AST_REQ_HOLD: assert property (req && !ack |=>
        req && $stable(cmd) && $stable(wdata))
        else $error("request changed before ack");
    AST_REQ_DROP: assert property (ack |=> !req)
        else $error("request held after ack");
    AST_CMD_MARK: assert property (req |-> cmd[7])
        else $error("command byte without top bit");
    AST_RESV_ZERO: assert property (ctrl_wr |-> wdata[7:2] == 6'h00)
        else $error("reserved control bits written nonzero");
    AST_PWR_WAIT: assert property (ack && ctrl_wr && wdata[1] |->
        last_pw && gap >= PWR_WAIT_CYC - 2)
        else $error("enable sent before power settled");
    AST_SPECIAL_SENDB: assert property (req && cmd[6:5] == 2'h3 |->
        sendb && !rd)
        else $error("special function not sent as send byte");
    AST_IRQ_FLAG: assert property (ack && rd && cmd[6:0] == 7'h00 |->
        rdata[5] == !irq_line)
        else $error("interrupt flag disagrees with wire");
endmodule

// *** lat_tb.sv ***
// self-checking bench: host and device ends joined by lat_if
// assumes short interval and power wait counts set below
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin \
    mismatches++; $display("wrong value %s exp %0h got %0h", n, e, g); \
    end end
module lat_tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int unsigned IV = 8;
    localparam int unsigned PW = 20;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        cyc = 1'b0;
    logic        stb = 1'b0;
    logic        we = 1'b0;
    logic        iset = 1'b0;
    logic [7:0]  adr = 8'h00;
    logic [31:0] wd = 32'h0;
    logic [31:0] rv;
    logic [31:0] dato;
    logic        acko, irqo, pwr, aen, integ, done;
    int          mismatches = 0;
    int          compares = 0;
    lat_if link ();
    lat_dev #(.INTERVAL_CYC(IV)) u_lat_dev (.clk_i(clk), .rst_i(rst),
        .link(link), .intr_set_i(iset), .powered_o(pwr), .adc_en_o(aen),
        .integrating_o(integ), .cycle_done_o(done));
    lat_host #(.PWR_WAIT_CYC(PW)) u_lat_host (.clk_i(clk), .rst_i(rst),
        .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
        .wb_sel_i(4'hF), .wb_dat_i(wd), .wb_dat_o(dato), .wb_ack_o(acko),
        .irq_o(irqo), .link(link));
    lat_sva #(.PWR_WAIT_CYC(PW)) u_lat_sva (.clk_i(clk), .rst_i(rst),
        .req(link.req), .cmd(link.cmd), .wdata(link.wdata), .rd(link.rd),
        .sendb(link.sendb), .ack(link.ack), .rdata(link.rdata),
        .irq_line(link.irq_line));
    always #2 clk = ~clk;
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wd <= d;
        do begin @(posedge clk); n++; end while (acko !== 1'b1 && n < 64);
        rv = dato;
        if (acko !== 1'b1) mismatches++;
        cyc <= 1'b0; stb <= 1'b0;
        @(posedge clk);
    endtask
    function automatic logic [31:0] cw(logic s, logic r, logic [1:0] t,
                                       logic [4:0] a, logic [7:0] d);
        return {14'h0, s, r, 1'b0, t, a, d};
    endfunction
    // polls busy; the power wait is hidden inside one command
    task automatic cmd(input logic [31:0] c);
        int n;
        n = 0;
        wb(1'b1, lat_pkg::WB_CMD, c);
        do begin wb(1'b0, lat_pkg::WB_STATUS, 32'h0); n++; end
        while (rv[0] !== 1'b0 && n < 40);
        if (rv[0] !== 1'b0) mismatches++;
    endtask
    task automatic dr(input logic [4:0] a, output logic [7:0] b);
        cmd(cw(1'b0, 1'b1, 2'h0, a, 8'h00));
        b = rv[15:8];
    endtask
    task automatic wt(output int c);
        c = 0;
        do begin @(posedge clk); c++; end while (done !== 1'b1 && c < 2100);
    endtask
    task automatic t_reset;
        logic [7:0] b;
        cmd(cw(1'b1, 1'b0, 2'h0, lat_pkg::ADR_PERIOD, 8'h80));
        `CHK("refused", 2'b10, rv[1:0])
        cmd(cw(1'b0, 1'b0, 2'h0, lat_pkg::ADR_CTRL, 8'h02));
        `CHK("refused", 2'b10, rv[1:0])
        dr(lat_pkg::ADR_CTRL, b);
        `CHK("ctrl reset", 8'h00, b)
        dr(lat_pkg::ADR_PERIOD, b);
        `CHK("period reset", 8'h00, b)
        wb(1'b0, 8'h10, 32'h0);
        `CHK("unmapped", 32'h0, rv)
        $display("t_reset done");
    endtask
    task automatic t_fixed;
        logic [7:0] k [3];
        logic [7:0] b;
        int c;
        k = '{8'hFF, 8'hFE, 8'h01};
        cmd(cw(1'b0, 1'b0, 2'h0, lat_pkg::ADR_PERIOD, 8'hFF));
        cmd(cw(1'b0, 1'b0, 2'h0, lat_pkg::ADR_CTRL, 8'hFF));
        `CHK("power", 2'b11, {aen, pwr})
        foreach (k[i]) begin
            cmd(cw(1'b0, 1'b0, 2'h0, lat_pkg::ADR_PERIOD, k[i]));
            wt(c); wt(c); wt(c);
            `CHK("period", (256 - k[i]) * IV, c)
        end
        dr(lat_pkg::ADR_CTRL, b);
        `CHK("done flag", 8'h13, b)
        $display("t_fixed done");
    endtask
    task automatic t_manual;
        logic [7:0] b;
        cmd(cw(1'b0, 1'b0, 2'h0, lat_pkg::ADR_PERIOD, 8'h00));
        cmd(cw(1'b1, 1'b0, 2'h3, lat_pkg::FN_START_MAN, 8'h00));
        `CHK("running", 1'b1, integ)
        repeat (40) @(posedge clk);
        cmd(cw(1'b1, 1'b0, 2'h3, lat_pkg::FN_STOP_MAN, 8'h00));
        `CHK("stopped", 1'b0, integ)
        dr(lat_pkg::ADR_MTIM_LO, b);
        `CHK("timer", 1'b1, b > 8'd3 && b < 8'd10)
        $display("t_manual done");
    endtask
    task automatic t_irq;
        logic [7:0] b;
        iset <= 1'b1;
        @(posedge clk);
        iset <= 1'b0;
        wb(1'b1, lat_pkg::WB_IRQ_MASK, 32'h4);
        cmd(cw(1'b0, 1'b0, 2'h0, lat_pkg::ADR_CTRL, 8'h23));
        dr(lat_pkg::ADR_CTRL, b);
        `CHK("irq flag", 1'b1, b[5])
        `CHK("irq out", 1'b1, irqo)
        cmd(cw(1'b1, 1'b0, 2'h3, lat_pkg::FN_INT_CLEAR, 8'h00));
        `CHK("irq wire", 1'b1, link.irq_line)
        wb(1'b1, lat_pkg::WB_IRQ_STAT, 32'h7);
        @(posedge clk);
        `CHK("irq cleared", 1'b0, irqo)
        cmd(cw(1'b0, 1'b0, 2'h0, lat_pkg::ADR_CTRL, 8'h00));
        `CHK("power off", 2'b00, {aen, pwr})
        $display("t_irq done");
    endtask
    task automatic wrap_up;
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    initial begin
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        t_reset;
        t_fixed;
        t_manual;
        t_irq;
        wrap_up;
    end
    initial begin
        repeat (30000) @(posedge clk);
        mismatches++;
        wrap_up;
    end
endmodule
